//--- design/dual_gpio_port.sv
// Purpose: ports seven and eight with latches, direction and timer pins
// Assumes: apb slave on sys_clk; timer controls arrive on sys_clk
// Notes: one cycle of access phase per transfer, pready from a flop
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dual_gpio_port (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire gpio_pkg::apb_req_t apb_req,
	output gpio_pkg::apb_rsp_t apb_rsp,
	input wire logic standby,
	input wire logic [3:0] timer_output_select_field,
	input wire logic timer_compare_output,
	input wire logic compare_a_output_enable,
	input wire logic compare_b_output_enable,
	input wire logic free_timer_compare_a_out,
	input wire logic free_timer_compare_b_out,
	input wire logic [7:0] p7_pin_i,
	output logic [7:0] p7_pin_o,
	output logic [7:0] p7_pin_oe_n,
	input wire logic [7:0] p8_pin_i,
	output logic [7:0] p8_pin_o,
	output logic [7:0] p8_pin_oe_n,
	output logic timer_external_clock_in,
	output logic timer_counter_reset_in
);

	typedef struct packed {
		logic [7:0] p7_data_r;
		logic [7:0] p8_data_r;
		logic [7:0] p7_dir_r;
		logic [7:0] p8_dir_r;
		gpio_pkg::apb_rsp_t rsp_r;
		logic tmr_clk_r;
		logic tmr_rst_r;
	} port_st_t;

	port_st_t st_r;
	port_st_t st_nxt;

	logic [7:0] p7_pin_s;
	logic [7:0] p8_pin_s;
	logic [7:0] p7_ovr_en;
	logic [7:0] p7_ovr_val;
	logic [7:0] p8_ovr_en;
	logic [7:0] p8_ovr_val;
	logic [7:0] p7_read;
	logic [7:0] p8_read;
	logic setup_w;
	logic commit_w;
	logic hit_p7_data;
	logic hit_p8_data;
	logic hit_p7_dir;
	logic hit_p8_dir;
	logic mapped_w;
	logic [7:0] wbyte;

	// pin levels are asynchronous; nothing looks at them before two stages
	pin_sync u_p7_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.din(p7_pin_i),
		.dout(p7_pin_s)
	);

	pin_sync u_p8_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.din(p8_pin_i),
		.dout(p8_pin_s)
	);

	// address decode
	assign hit_p7_data = apb_req.paddr == gpio_pkg::ADDR_P7_DATA;
	assign hit_p8_data = apb_req.paddr == gpio_pkg::ADDR_P8_DATA;
	assign hit_p7_dir = apb_req.paddr == gpio_pkg::ADDR_P7_DIR;
	assign hit_p8_dir = apb_req.paddr == gpio_pkg::ADDR_P8_DIR;
	assign mapped_w = hit_p7_data | hit_p8_data | hit_p7_dir | hit_p8_dir;

	assign setup_w = apb_req.psel & ~apb_req.penable;
	// a write lands only on the edge where the master sees pready
	assign commit_w = apb_req.psel & apb_req.penable & st_r.rsp_r.pready
		& apb_req.pwrite & mapped_w;
	assign wbyte = apb_req.pwdata[7:0];

	// read value per bit: latch for outputs, pin for inputs
	assign p7_read = (st_r.p7_dir_r & st_r.p7_data_r)
		| (~st_r.p7_dir_r & p7_pin_s);
	assign p8_read = (st_r.p8_dir_r & st_r.p8_data_r)
		| (~st_r.p8_dir_r & p8_pin_s);

	// timer functions that take over pins regardless of direction
	always_comb begin
		p7_ovr_en = gpio_pkg::BYTE_ZERO;
		p7_ovr_val = gpio_pkg::BYTE_ZERO;
		p8_ovr_en = gpio_pkg::BYTE_ZERO;
		p8_ovr_val = gpio_pkg::BYTE_ZERO;
		p7_ovr_en[gpio_pkg::P7_TMR_OUT_BIT] =
			timer_output_select_field != gpio_pkg::OS_OFF;
		p7_ovr_val[gpio_pkg::P7_TMR_OUT_BIT] = timer_compare_output;
		p8_ovr_en[gpio_pkg::P8_CMP_A_BIT] = compare_a_output_enable;
		p8_ovr_val[gpio_pkg::P8_CMP_A_BIT] = free_timer_compare_a_out;
		p8_ovr_en[gpio_pkg::P8_CMP_B_BIT] = compare_b_output_enable;
		p8_ovr_val[gpio_pkg::P8_CMP_B_BIT] = free_timer_compare_b_out;
	end

	always_comb begin
		st_nxt = st_r;

		// register writes
		if (commit_w && hit_p7_data) begin
			st_nxt.p7_data_r = wbyte;
		end
		if (commit_w && hit_p8_data) begin
			st_nxt.p8_data_r = wbyte;
		end
		if (commit_w && hit_p7_dir) begin
			st_nxt.p7_dir_r = wbyte;
		end
		if (commit_w && hit_p8_dir) begin
			st_nxt.p8_dir_r = wbyte;
		end

		// answer prepared in setup, shown for exactly one access cycle;
		// pin reads are thus sampled one edge before the master takes them
		st_nxt.rsp_r.pready = setup_w;
		st_nxt.rsp_r.pslverr = setup_w & ~mapped_w;
		st_nxt.rsp_r.prdata = gpio_pkg::RDATA_ZERO;
		if (setup_w && !apb_req.pwrite) begin
			if (hit_p7_data) begin
				st_nxt.rsp_r.prdata = {gpio_pkg::RDATA_PAD, p7_read};
			end else if (hit_p8_data) begin
				st_nxt.rsp_r.prdata = {gpio_pkg::RDATA_PAD, p8_read};
			end else if (hit_p7_dir) begin
				st_nxt.rsp_r.prdata = {gpio_pkg::RDATA_PAD, gpio_pkg::DIR_READ};
			end else if (hit_p8_dir) begin
				st_nxt.rsp_r.prdata = {gpio_pkg::RDATA_PAD, gpio_pkg::DIR_READ};
			end
		end

		// timer inputs follow the pins in either direction
		st_nxt.tmr_clk_r = p7_pin_s[gpio_pkg::P7_TMR_CLK_BIT];
		st_nxt.tmr_rst_r = p7_pin_s[gpio_pkg::P7_TMR_RST_BIT];
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_r.p7_data_r <= gpio_pkg::DATA_RST;
			st_r.p8_data_r <= gpio_pkg::DATA_RST;
			st_r.p7_dir_r <= gpio_pkg::DIR_RST;
			st_r.p8_dir_r <= gpio_pkg::DIR_RST;
			st_r.rsp_r <= '0;
			st_r.tmr_clk_r <= 1'b0;
			st_r.tmr_rst_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// pin drivers; their flops reset to released, standby releases too
	pin_drive u_p7_drive (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.latch(st_r.p7_data_r),
		.dir(st_r.p7_dir_r),
		.ovr_en(p7_ovr_en),
		.ovr_val(p7_ovr_val),
		.release_all(standby),
		.pin_o(p7_pin_o),
		.pin_oe_n(p7_pin_oe_n)
	);

	pin_drive u_p8_drive (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.latch(st_r.p8_data_r),
		.dir(st_r.p8_dir_r),
		.ovr_en(p8_ovr_en),
		.ovr_val(p8_ovr_val),
		.release_all(standby),
		.pin_o(p8_pin_o),
		.pin_oe_n(p8_pin_oe_n)
	);

	assign apb_rsp = st_r.rsp_r;
	assign timer_external_clock_in = st_r.tmr_clk_r;
	assign timer_counter_reset_in = st_r.tmr_rst_r;

endmodule : dual_gpio_port
`default_nettype wire

//--- design/gpio_pkg.sv
// Purpose: shared constants and carriers for the dual gpio port block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: register index times four gives the byte address
package gpio_pkg;

	localparam int PORT_W = 8;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int IDX_W = 16;
	localparam int OS_W = 4;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_P7_DATA = 16'hffda;
	localparam logic [IDX_W-1:0] IDX_P8_DATA = 16'hffdb;
	localparam logic [IDX_W-1:0] IDX_P7_DIR = 16'hffea;
	localparam logic [IDX_W-1:0] IDX_P8_DIR = 16'hffeb;
	localparam logic [1:0] WORD_LSB = 2'h0;

	localparam logic [ADDR_W-1:0] ADDR_P7_DATA = {IDX_P7_DATA, WORD_LSB};
	localparam logic [ADDR_W-1:0] ADDR_P8_DATA = {IDX_P8_DATA, WORD_LSB};
	localparam logic [ADDR_W-1:0] ADDR_P7_DIR = {IDX_P7_DIR, WORD_LSB};
	localparam logic [ADDR_W-1:0] ADDR_P8_DIR = {IDX_P8_DIR, WORD_LSB};

	localparam logic [PORT_W-1:0] DATA_RST = 8'h00;
	localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
	localparam logic [PORT_W-1:0] DIR_READ = 8'hff;
	localparam logic [PORT_W-1:0] OE_N_OFF = 8'hff;
	localparam logic [PORT_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-PORT_W-1:0] RDATA_PAD = 24'h000000;
	localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;
	localparam logic [OS_W-1:0] OS_OFF = 4'h0;

	// shared pin positions
	localparam int P7_TMR_OUT_BIT = 6;
	localparam int P7_TMR_CLK_BIT = 5;
	localparam int P7_TMR_RST_BIT = 4;
	localparam int P8_CMP_A_BIT = 1;
	localparam int P8_CMP_B_BIT = 2;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic [DATA_W-1:0] prdata;
		logic pslverr;
	} apb_rsp_t;

endpackage : gpio_pkg

//--- design/pin_sync.sv
// Purpose: two-stage synchroniser for a byte of pin levels
// Assumes: pins are asynchronous to sys_clk
// Notes: only the second stage may be read by other logic
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] din,
	output logic [7:0] dout
);

	typedef struct packed {
		logic [7:0] meta_r;
		logic [7:0] sync_r;
	} sync_st_t;

	sync_st_t st_r;
	sync_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.meta_r = din;
		st_nxt.sync_r = st_r.meta_r;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.sync_r;

endmodule : pin_sync
`default_nettype wire

//--- design/pin_drive.sv
// Purpose: registered output and enable for one eight-pin port
// Assumes: override controls come from timer logic on sys_clk
// Notes: enable is active low; port reads follow the direction bit, so an output pin released by standby still reads its latch
`timescale 1ns/1ps
`default_nettype none
module pin_drive (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] latch,
	input wire logic [7:0] dir,
	input wire logic [7:0] ovr_en,
	input wire logic [7:0] ovr_val,
	input wire logic release_all,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_n
);

	typedef struct packed {
		logic [7:0] out_r;
		logic [7:0] oe_n_r;
	} drive_st_t;

	drive_st_t st_r;
	drive_st_t st_nxt;
	logic [7:0] val_w;
	logic [7:0] oe_n_w;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bit
			// a timer function owns the pin whatever the direction bit says
			assign val_w[gi] = ovr_en[gi] ? ovr_val[gi] : latch[gi];
			assign oe_n_w[gi] = release_all | ~(ovr_en[gi] | dir[gi]);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		st_nxt.out_r = val_w;
		st_nxt.oe_n_r = oe_n_w;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_r <= {gpio_pkg::BYTE_ZERO, gpio_pkg::OE_N_OFF};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_o = st_r.out_r;
	assign pin_oe_n = st_r.oe_n_r;

endmodule : pin_drive
`default_nettype wire

//--- bench/dual_gpio_port_assertions.sv
// Purpose: port-level checks for dual_gpio_port
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the testbench top
`timescale 1ns/1ps
`default_nettype none
module dual_gpio_port_assertions (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire gpio_pkg::apb_req_t apb_req,
	input wire gpio_pkg::apb_rsp_t apb_rsp,
	input wire logic standby,
	input wire logic [3:0] timer_output_select_field,
	input wire logic timer_compare_output,
	input wire logic compare_a_output_enable,
	input wire logic free_timer_compare_a_out,
	input wire logic [7:0] p7_pin_i,
	input wire logic [7:0] p7_pin_o,
	input wire logic [7:0] p7_pin_oe_n,
	input wire logic [7:0] p8_pin_o,
	input wire logic [7:0] p8_pin_oe_n,
	input wire logic timer_external_clock_in,
	input wire logic timer_counter_reset_in
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_ready_one_cycle: assert property (
		apb_req.psel && !apb_req.penable |=> apb_rsp.pready) else $error("pready late");
	chk_ready_pulse: assert property (
		apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
	chk_slverr_ready: assert property (
		apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
		else $error("bad error response");
	chk_dir_reads_ones: assert property (
		apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
		(apb_req.paddr == gpio_pkg::ADDR_P7_DIR || apb_req.paddr == gpio_pkg::ADDR_P8_DIR)
		|=> apb_rsp.prdata == 32'hff) else $error("direction read not ones");
	chk_standby_release: assert property (
		standby |=> p7_pin_oe_n == 8'hff && p8_pin_oe_n == 8'hff)
		else $error("pin driven in standby");
	chk_tmr_pin_six: assert property (
		timer_output_select_field != 4'h0 && !standby |=> !p7_pin_oe_n[6] &&
		p7_pin_o[6] == $past(timer_compare_output)) else $error("pin six not timer");
	chk_cmp_a_pin: assert property (
		compare_a_output_enable && !standby |=> !p8_pin_oe_n[1] &&
		p8_pin_o[1] == $past(free_timer_compare_a_out)) else $error("pin one not compare");
	// guard keeps reset-time pin history out of the comparison
	chk_tmr_inputs: assert property (
		$past(nrst, 3) && $past(nrst, 2) && $past(nrst) |->
		{timer_external_clock_in, timer_counter_reset_in} == $past(p7_pin_i[5:4], 3))
		else $error("timer inputs wrong");
endmodule : dual_gpio_port_assertions
`default_nettype wire

//--- bench/test_dual_gpio_port.sv
// Purpose: directed apb test of dual_gpio_port
// Assumes: zero wait states, but waits on pready anyway
// Notes: outputs are read a few edges after each change
`timescale 1ns/1ps
`default_nettype none
module test_dual_gpio_port;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	gpio_pkg::apb_req_t apb_req = '0;
	gpio_pkg::apb_rsp_t apb_rsp;
	logic standby = 1'b0;
	logic [3:0] timer_output_select_field = 4'h0;
	logic timer_compare_output = 1'b1;
	logic compare_a_output_enable = 1'b0;
	logic compare_b_output_enable = 1'b0;
	logic free_timer_compare_a_out = 1'b1;
	logic free_timer_compare_b_out = 1'b0;
	logic [7:0] p7_pin_i = 8'h5a;
	logic [7:0] p8_pin_i = 8'ha5;
	logic [7:0] p7_pin_o, p7_pin_oe_n, p8_pin_o, p8_pin_oe_n, pin;
	logic timer_external_clock_in, timer_counter_reset_in, err;
	logic [31:0] rd;
	logic [17:0] da, ca;
	int num_errors = 0;
	int checked = 0;
	dual_gpio_port dual_gpio_port_inst (.sys_clk, .nrst, .apb_req, .apb_rsp, .standby,
		.timer_output_select_field, .timer_compare_output, .compare_a_output_enable,
		.compare_b_output_enable, .free_timer_compare_a_out, .free_timer_compare_b_out,
		.p7_pin_i, .p7_pin_o, .p7_pin_oe_n, .p8_pin_i, .p8_pin_o, .p8_pin_oe_n,
		.timer_external_clock_in, .timer_counter_reset_in);
	always #25 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// starts on a rising edge so that checks made on a falling edge never launch it
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		// response flops are settled mid-cycle; what stands there is what the edge sees
		forever begin
			@(negedge sys_clk);
			if (apb_rsp.pready === 1'b1) break;
		end
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		@(posedge sys_clk);
		apb_req <= '0;
		@(posedge sys_clk);
	endtask : apb
	task automatic rdchk(input logic [17:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk
	task automatic end_of_test;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (2000) @(posedge sys_clk);
		num_errors++;
		end_of_test;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		for (int p = 0; p < 2; p++) begin
			da = p ? gpio_pkg::ADDR_P8_DATA : gpio_pkg::ADDR_P7_DATA;
			ca = p ? gpio_pkg::ADDR_P8_DIR : gpio_pkg::ADDR_P7_DIR;
			pin = p ? p8_pin_i : p7_pin_i;
			@(negedge sys_clk);
			chk(p ? p8_pin_oe_n : p7_pin_oe_n, 32'hff);
			rdchk(da, {24'h0, pin});
			rdchk(ca, 32'hff);
			apb(1'b1, ca, 32'hffffff0f);
			rdchk(da, {24'h0, pin[7:4], 4'h0});
			apb(1'b1, da, 32'h000000c3);
			rdchk(da, {24'h0, pin[7:4], 4'h3});
			rdchk(ca, 32'hff);
			@(negedge sys_clk);
			chk(p ? p8_pin_oe_n : p7_pin_oe_n, 32'hf0);
			chk((p ? p8_pin_o : p7_pin_o) & 8'h0f, 32'h3);
			apb(1'b1, ca, 32'h0);
			$display("test %0d done", p);
		end
		apb(1'b0, 18'h00100, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		for (int s = 0; s < 16; s++) begin
			@(posedge sys_clk);
			timer_output_select_field <= s[3:0];
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			chk(p7_pin_oe_n, s ? 32'hbf : 32'hff);
		end
		@(posedge sys_clk);
		timer_output_select_field <= 4'h0;
		compare_a_output_enable <= 1'b1;
		compare_b_output_enable <= 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(p8_pin_oe_n, 32'hf9);
		chk(p8_pin_o[2:1], 32'h1);
		$display("test 2 done");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, gpio_pkg::ADDR_P7_DIR, i ? 32'hff : 32'h0);
			p7_pin_i <= 8'h10 << i;
			repeat (4) @(posedge sys_clk);
			@(negedge sys_clk);
			chk({timer_external_clock_in, timer_counter_reset_in}, 32'h1 << i);
		end
		@(posedge sys_clk);
		standby <= 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({p7_pin_oe_n, p8_pin_oe_n}, 32'hffff);
		@(posedge sys_clk);
		standby <= 1'b0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(p8_pin_oe_n, 32'hf9);
		$display("test 3 done");
		end_of_test;
	end
endmodule : test_dual_gpio_port
bind dual_gpio_port dual_gpio_port_assertions dual_gpio_port_assertions_inst (.sys_clk,
	.nrst, .apb_req, .apb_rsp, .standby, .timer_output_select_field, .timer_compare_output,
	.compare_a_output_enable, .free_timer_compare_a_out, .p7_pin_i, .p7_pin_o,
	.p7_pin_oe_n, .p8_pin_o, .p8_pin_oe_n, .timer_external_clock_in,
	.timer_counter_reset_in);
`default_nettype wire
